// File: rtl/iapr_regs.svh
// Purpose: Offsets, field positions and reset values of the acknowledge resolver
// Assumes: Word-aligned byte addresses on a 10-bit Avalon-MM address
// Notes:   Definitions only, no logic
`ifndef IAPR_REGS_SVH
`define IAPR_REGS_SVH

// Word index = byte address [9:2]
`define IAPR_IDX_LP        8'h00
`define IAPR_IDX_SW        8'h01
// Groups on index[7:3]: level ack at 0x20+4m, global level ack at 0x40+4m
`define IAPR_GRP_LVL       5'h01
`define IAPR_GRP_GLVL      5'h02
// Source control at 0x100+4x, group on index[7:6]
`define IAPR_GRP_CTRL      2'h1

// Source control fields
`define IAPR_CTL_LVL_HI    5
`define IAPR_CTL_LVL_LO    3
`define IAPR_CTL_PRI_HI    2
`define IAPR_CTL_PRI_LO    0
`define IAPR_CTL_RST       6'h00

// Acknowledge level/priority fields
`define IAPR_LP_LVL_HI     6
`define IAPR_LP_LVL_LO     4
`define IAPR_LP_PRI_HI     3
`define IAPR_LP_PRI_LO     0
`define IAPR_LP_RST        8'h00

// Rank codes and keys
`define IAPR_MID_RANK      4'h8
`define IAPR_MID_KEY       4'h7
`define IAPR_FIXED_LAST    6'h07
`define IAPR_FIRST_RW      6'h08

// Vector mapping
`define IAPR_VEC_BASE      8'h40
`define IAPR_VEC_NONE      8'h00
`define IAPR_RD_PAD        24'h000000

`endif

// File: rtl/iapr_pkg.sv
// Purpose: Types shared by the acknowledge resolver
// Assumes: Up to 63 sources, 8-bit vectors
// Notes:   Constants live in iapr_regs.svh
package iapr_pkg;
  typedef logic [7:0]  iapr_vec_type;
  typedef logic [63:0] iapr_src_type;
  typedef enum logic [2:0] {
    iapr_k_none, iapr_k_lp, iapr_k_sw, iapr_k_lvl, iapr_k_glvl, iapr_k_ctrl
  } iapr_kind_type;
  typedef struct packed {
    logic       found;
    logic [5:0] src;
    logic [2:0] lvl;
    logic [3:0] prio;
  } iapr_hit_type;
endpackage : iapr_pkg

// File: rtl/iapr_resolver.sv
// Purpose: Acknowledge and priority resolution for up to 63 interrupt sources
// Assumes: Mask, force and raw request vectors come in synchronous to clk_sys
// Notes:   Bus and implicit acknowledge share one arbiter; the bus wins a tie
`timescale 1ns/100ps
`include "iapr_regs.svh"

module iapr_resolver #(
  parameter int NUM_SRC = 63
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic [9:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  input  wire iapr_pkg::iapr_src_type irq_raw,
  input  wire iapr_pkg::iapr_src_type mask_in,
  input  wire iapr_pkg::iapr_src_type force_in,
  input  wire logic                   interrupt_acknowledge_valid,
  input  wire logic [2:0]             interrupt_acknowledge_level,
  output iapr_pkg::iapr_vec_type      interrupt_acknowledge_vector,
  output logic                        interrupt_acknowledge_done
);
  import iapr_pkg::*;

  // Index width fixes the top of the range
  if (NUM_SRC < 8 || NUM_SRC > 63) begin : g_bad_num
    $error("NUM_SRC must lie in 8..63");
  end

  logic [5:0]    ctrl_r [0:63];
  logic [7:0]    ack_lp_r;
  logic [31:0]   readdata_r;
  logic          waitrequest_r;
  iapr_vec_type  interrupt_acknowledge_vector_r;
  logic          interrupt_acknowledge_done_r;
  logic          sw_q_r;
  logic          rd_fixed_r;
  logic          rd_none_r;
  iapr_src_type  live_q_r;
  iapr_src_type  blocked_q_r;

  logic [7:0]    idx;
  iapr_kind_type kind;
  logic          bus_req;
  logic          ack_take;
  logic          interrupt_acknowledge_take;
  logic          sel_any;
  logic [2:0]    sel_level;
  iapr_src_type  mask_eff;
  iapr_src_type  active;
  iapr_hit_type  hit;
  logic [7:0]    hit_vec;
  logic [7:0]    hit_lp;
  logic [7:0]    rd_val;

  // Control byte as seen by the arbiter and by a read
  function automatic logic [5:0] ctrl_view(input logic [5:0] src);
    if (src <= `IAPR_FIXED_LAST) begin
      ctrl_view = {src[2:0], 3'h0};
    end else begin
      ctrl_view = ctrl_r[src];
    end
  endfunction : ctrl_view

  // Address decode into register kinds
  function automatic iapr_kind_type decode_kind(input logic [7:0] i);
    if (i == `IAPR_IDX_LP) begin
      decode_kind = iapr_k_lp;
    end else if (i == `IAPR_IDX_SW) begin
      decode_kind = iapr_k_sw;
    end else if (i[7:3] == `IAPR_GRP_LVL && i[2:0] != 3'h0) begin
      decode_kind = iapr_k_lvl;
    end else if (i[7:3] == `IAPR_GRP_GLVL && i[2:0] != 3'h0) begin
      decode_kind = iapr_k_glvl;
    end else if (i[7:6] == `IAPR_GRP_CTRL && i[5:0] != 6'h00 && i[5:0] <= 6'(NUM_SRC)) begin
      decode_kind = iapr_k_ctrl;
    end else begin
      decode_kind = iapr_k_none;
    end
  endfunction : decode_kind

  // Request decode; waitrequest high marks a request not yet served
  assign idx       = avs_address[9:2];
  assign kind      = decode_kind(idx);
  assign bus_req   = (avs_read || avs_write) && waitrequest_r;
  assign ack_take  = bus_req && avs_read &&
                     (kind == iapr_k_sw || kind == iapr_k_lvl || kind == iapr_k_glvl);
  // Acknowledge cycle is served only when the bus is idle this edge
  assign interrupt_acknowledge_take = !bus_req && interrupt_acknowledge_valid && !interrupt_acknowledge_done_r;
  assign sel_any   = bus_req && kind == iapr_k_sw;
  assign sel_level = bus_req ? idx[2:0] : interrupt_acknowledge_level;

  // Effective requests: mask-all overrides, force bypasses the mask
  assign mask_eff  = mask_in | {64{mask_in[0]}};
  assign active    = ((irq_raw & ~mask_eff) | force_in) & ~64'h1;

  // Linear scan; rank key doubles programmable priority so fixed sit mid-level
  always_comb begin
    logic [5:0] v;
    logic [3:0] key;
    logic [6:0] best;
    logic       fixed;
    v     = 6'h00;
    key   = 4'h0;
    best  = 7'h00;
    fixed = 1'b0;
    hit   = '0;
    for (int i = 1; i <= NUM_SRC; i++) begin
      v     = ctrl_view(6'(i));
      fixed = 6'(i) <= `IAPR_FIXED_LAST;
      key   = fixed ? `IAPR_MID_KEY : {v[`IAPR_CTL_PRI_HI:`IAPR_CTL_PRI_LO], 1'b0};
      if (active[i] && v[`IAPR_CTL_LVL_HI:`IAPR_CTL_LVL_LO] != 3'h0 &&
          (sel_any || v[`IAPR_CTL_LVL_HI:`IAPR_CTL_LVL_LO] == sel_level) &&
          {v[`IAPR_CTL_LVL_HI:`IAPR_CTL_LVL_LO], key} > best) begin
        best      = {v[`IAPR_CTL_LVL_HI:`IAPR_CTL_LVL_LO], key};
        hit.found = 1'b1;
        hit.src   = 6'(i);
        hit.lvl   = v[`IAPR_CTL_LVL_HI:`IAPR_CTL_LVL_LO];
        hit.prio  = fixed ? `IAPR_MID_RANK : {1'b0, v[`IAPR_CTL_PRI_HI:`IAPR_CTL_PRI_LO]};
      end
    end
  end

  // Vector and record from the winner; zero means nothing won
  assign hit_vec = hit.found ? `IAPR_VEC_BASE + {2'h0, hit.src} : `IAPR_VEC_NONE;
  assign hit_lp  = hit.found ? {1'b0, hit.lvl, hit.prio} : `IAPR_LP_RST;

  // Read mux; unmapped words read zero
  always_comb begin
    case (kind)
      iapr_k_lp:   rd_val = ack_lp_r;
      iapr_k_sw,
      iapr_k_lvl,
      iapr_k_glvl: rd_val = hit_vec;
      iapr_k_ctrl: rd_val = {2'h0, ctrl_view(idx[5:0])};
      default:     rd_val = `IAPR_VEC_NONE;
    endcase
  end

  // Bus handshake: answer one edge after the request is seen
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      waitrequest_r <= 1'b1;
      readdata_r    <= 32'h0;
    end else if (bus_req) begin
      waitrequest_r <= 1'b0;
      if (avs_read) begin
        readdata_r <= {`IAPR_RD_PAD, rd_val};
      end
    end else begin
      waitrequest_r <= 1'b1;
    end
  end

  // Source control storage; fixed entries never take a write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < 64; i++) begin
        ctrl_r[i] <= `IAPR_CTL_RST;
      end
    end else if (bus_req && avs_write && kind == iapr_k_ctrl &&
                 idx[5:0] >= `IAPR_FIRST_RW && avs_byteenable[0]) begin
      ctrl_r[idx[5:0]] <= avs_writedata[5:0];
    end
  end

  // Record reload on any acknowledge, bus or cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_lp_r <= `IAPR_LP_RST;
    end else if (ack_take || interrupt_acknowledge_take) begin
      ack_lp_r <= hit_lp;
    end
  end

  // Acknowledge cycle port; done pulses one cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      interrupt_acknowledge_done_r   <= 1'b0;
      interrupt_acknowledge_vector_r <= `IAPR_VEC_NONE;
    end else begin
      interrupt_acknowledge_done_r <= interrupt_acknowledge_take;
      if (interrupt_acknowledge_take) begin
        interrupt_acknowledge_vector_r <= hit_vec;
      end
    end
  end

  // Helper flags for checking only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sw_q_r     <= 1'b0;
      rd_fixed_r <= 1'b0;
      rd_none_r  <= 1'b0;
    end else begin
      sw_q_r     <= sel_any && avs_read;
      rd_fixed_r <= bus_req && avs_read && kind == iapr_k_ctrl && idx[5:0] <= `IAPR_FIXED_LAST;
      rd_none_r  <= bus_req && avs_read && kind == iapr_k_none;
    end
  end

  // Arbiter inputs captured at each edge, for checking only
  // The winner seen one cycle later must have been live and not blocked then
  // Costs two wide registers that synthesis drops with the assertions
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      live_q_r    <= '0;
      blocked_q_r <= '0;
    end else begin
      live_q_r    <= active;
      blocked_q_r <= mask_eff & ~force_in;
    end
  end

  assign avs_readdata    = readdata_r;
  assign avs_waitrequest = waitrequest_r;
  assign interrupt_acknowledge_vector     = interrupt_acknowledge_vector_r;
  assign interrupt_acknowledge_done       = interrupt_acknowledge_done_r;

  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  AST_WAIT_ANSWER: assert property ((avs_read || avs_write) && waitrequest_r |=> !waitrequest_r ##1 waitrequest_r)
    else $error("bus answer not one cycle after request");
  AST_LP_RSVD: assert property (ack_lp_r[7] == 1'b0 && avs_readdata[31:8] == 24'h0)
    else $error("reserved bits set");
  AST_LP_PRIO: assert property (ack_lp_r[`IAPR_LP_PRI_HI:`IAPR_LP_PRI_LO] <= 4'h8)
    else $error("record priority out of range");
  AST_EMPTY_INTERRUPT_ACKNOWLEDGE: assert property (interrupt_acknowledge_done_r && interrupt_acknowledge_vector_r == 8'h00 |-> ack_lp_r == 8'h00)
    else $error("empty acknowledge left record set");
  AST_INTERRUPT_ACKNOWLEDGE_LEVEL: assert property (interrupt_acknowledge_done_r && interrupt_acknowledge_vector_r != 8'h00
                                   |-> ack_lp_r[`IAPR_LP_LVL_HI:`IAPR_LP_LVL_LO] == $past(interrupt_acknowledge_level))
    else $error("record level differs from acknowledged level");
  AST_FIXED_WIN: assert property (interrupt_acknowledge_done_r && interrupt_acknowledge_vector_r > 8'h40 && interrupt_acknowledge_vector_r < 8'h48
                                  |-> ack_lp_r == {1'b0, interrupt_acknowledge_vector_r[2:0], 4'h8})
    else $error("fixed source not recorded at mid-point");
  AST_SW_EMPTY: assert property (sw_q_r && avs_readdata[7:0] == 8'h00 |-> ack_lp_r == 8'h00)
    else $error("empty software acknowledge left record set");
  AST_SW_LOAD: assert property (sw_q_r && avs_readdata[7:0] != 8'h00
                                |-> ack_lp_r[`IAPR_LP_LVL_HI:`IAPR_LP_LVL_LO] != 3'h0)
    else $error("software acknowledge did not load record");
  AST_FIXED_RO: assert property (rd_fixed_r |-> avs_readdata[2:0] == 3'h0 && avs_readdata[7:6] == 2'h0)
    else $error("fixed source control priority not zero");
  AST_MASK_ALL: assert property (interrupt_acknowledge_done_r && $past(mask_in[0]) && $past(force_in) == 64'h0
                                 |-> interrupt_acknowledge_vector_r == 8'h00)
    else $error("mask-all did not silence acknowledge");
  AST_VEC_RANGE: assert property (interrupt_acknowledge_done_r && interrupt_acknowledge_vector_r != 8'h00
                                  |-> interrupt_acknowledge_vector_r > 8'h40 && interrupt_acknowledge_vector_r < 8'h80)
    else $error("vector outside source mapping");

  // Handshake timing of both request paths
  // Waitrequest low lasts one cycle so a held request is not served twice by accident
  AST_WAIT_ONE: assert property (!waitrequest_r |=> waitrequest_r)
    else $error("waitrequest low longer than one cycle");
  AST_DONE_PULSE: assert property (interrupt_acknowledge_done_r |=> !interrupt_acknowledge_done_r)
    else $error("acknowledge done longer than one cycle");
  AST_INTERRUPT_ACKNOWLEDGE_ANSWER: assert property (interrupt_acknowledge_valid && !interrupt_acknowledge_done_r && !bus_req |=> interrupt_acknowledge_done_r)
    else $error("acknowledge cycle not answered in one cycle");
  // Bus wins a same-edge tie; the cycle is served one edge later
  AST_BUS_FIRST: assert property (bus_req && interrupt_acknowledge_valid |=> !interrupt_acknowledge_done_r)
    else $error("acknowledge cycle served during a bus transfer");
  AST_VEC_STANDS: assert property (!interrupt_acknowledge_done_r |-> $stable(interrupt_acknowledge_vector_r))
    else $error("acknowledge vector moved without an acknowledge");

  // Winner must be a live, unblocked source at the edge it was chosen
  AST_WIN_ACTIVE: assert property (interrupt_acknowledge_done_r && interrupt_acknowledge_vector_r != 8'h00
                                   |-> live_q_r[interrupt_acknowledge_vector_r[5:0]])
    else $error("acknowledge returned an inactive source");
  AST_WIN_UNMASKED: assert property (interrupt_acknowledge_done_r && interrupt_acknowledge_vector_r != 8'h00
                                     |-> !blocked_q_r[interrupt_acknowledge_vector_r[5:0]])
    else $error("acknowledge returned a masked source");
  AST_SW_ACTIVE: assert property (sw_q_r && avs_readdata[7:0] != 8'h00
                                  |-> live_q_r[avs_readdata[5:0]] && !blocked_q_r[avs_readdata[5:0]])
    else $error("software acknowledge returned a blocked source");
  AST_SW_RANGE: assert property (sw_q_r && avs_readdata[7:0] != 8'h00
                                 |-> avs_readdata[7:0] > 8'h40 && avs_readdata[7:0] < 8'h80)
    else $error("software vector outside source mapping");
  // Level zero marks a disabled source, so an acknowledge there finds nothing
  AST_INTERRUPT_ACKNOWLEDGE_LVL0: assert property (interrupt_acknowledge_done_r && $past(interrupt_acknowledge_level) == 3'h0
                                  |-> interrupt_acknowledge_vector_r == 8'h00 && ack_lp_r == 8'h00)
    else $error("level zero acknowledge returned a source");

  // Record layout and side effects
  AST_LP_LEVEL: assert property (ack_lp_r != 8'h00
                                 |-> ack_lp_r[`IAPR_LP_LVL_HI:`IAPR_LP_LVL_LO] != 3'h0)
    else $error("record holds a source at level zero");
  // Reading the record must not disturb it, or a handler loses its context
  AST_LP_NOLOAD: assert property (bus_req && avs_read && kind == iapr_k_lp |=> $stable(ack_lp_r))
    else $error("record read changed the record");

  // Control storage: writable entries land, fixed entries never move
  AST_CTRL_WRITE: assert property (bus_req && avs_write && kind == iapr_k_ctrl &&
                                   idx[5:0] >= `IAPR_FIRST_RW && avs_byteenable[0]
                                   |=> ctrl_r[$past(idx[5:0])] == $past(avs_writedata[5:0]))
    else $error("control write did not land");
  AST_CTRL_RO: assert property (bus_req && avs_write && kind == iapr_k_ctrl && idx[5:0] <= `IAPR_FIXED_LAST
                                |=> ctrl_r[$past(idx[5:0])] == $past(ctrl_r[idx[5:0]]))
    else $error("fixed source control took a write");
  // Unmapped words read zero so software never mistakes them for a vector
  AST_RD_NONE: assert property (rd_none_r |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");

  COV_SW_HIT: cover property (sw_q_r && avs_readdata[7:0] != 8'h00);
  COV_INTERRUPT_ACKNOWLEDGE_EMPTY: cover property (interrupt_acknowledge_done_r && interrupt_acknowledge_vector_r == 8'h00);
  COV_FIXED_WIN: cover property (interrupt_acknowledge_done_r && ack_lp_r[3:0] == 4'h8);
  COV_CTRL_WRITE: cover property (bus_req && avs_write && kind == iapr_k_ctrl);
  COV_COLLIDE: cover property (bus_req && interrupt_acknowledge_valid && !interrupt_acknowledge_done_r);

endmodule : iapr_resolver

// File: dv/iapr_core_model.sv
// Purpose: Processor-side model running implicit acknowledge cycles
// Assumes: One acknowledge outstanding at a time
// Notes:   Level lines show the inverse value while idle
`timescale 1ns/100ps
module iapr_core_model (
  input  wire logic       clk_sys,
  output logic            interrupt_acknowledge_valid,
  output logic [2:0]      interrupt_acknowledge_level,
  input  wire logic [7:0] interrupt_acknowledge_vector,
  input  wire logic       interrupt_acknowledge_done
);
  initial begin
    interrupt_acknowledge_valid = 1'b0;
    interrupt_acknowledge_level = 3'h0;
  end

  // Hold the request until done is sampled; gap makes a slow core
  task automatic ack(input logic [2:0] lvl, input int gap, output logic [7:0] vec, output bit ok);
    ok  = 1'b0;
    vec = 8'h00;
    repeat (gap) @(posedge clk_sys);
    interrupt_acknowledge_valid <= 1'b1;
    interrupt_acknowledge_level <= lvl;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(posedge clk_sys);
      if (interrupt_acknowledge_done === 1'b1) begin
        vec = interrupt_acknowledge_vector;
        ok  = 1'b1;
      end
    end
    interrupt_acknowledge_valid <= 1'b0;
    interrupt_acknowledge_level <= ~lvl;
  endtask : ack
endmodule : iapr_core_model

// File: dv/tb.sv
// Purpose: Self-checking bench for the acknowledge resolver
// Assumes: Bus answers on its own schedule, bounded waits only
// Notes:   Table rows hold plain arbitration cases
`timescale 1ns/100ps
module tb;
  import iapr_pkg::*;
  typedef struct {
    logic [63:0] irq, msk, frc;
    logic [9:0]  adr;
    logic [7:0]  vec, lp;
  } iapr_row_type;
  logic         clk_sys, rst, avs_read, avs_write, avs_waitrequest, interrupt_acknowledge_valid, interrupt_acknowledge_done;
  logic [9:0]   avs_address;
  logic [31:0]  avs_writedata, avs_readdata;
  logic [3:0]   avs_byteenable;
  logic [2:0]   interrupt_acknowledge_level;
  iapr_src_type irq_raw, mask_in, force_in;
  iapr_vec_type interrupt_acknowledge_vector;
  iapr_row_type rows[11];
  int           n_fail, cmp_count;

  iapr_resolver iapr_resolver_inst (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq_raw(irq_raw), .mask_in(mask_in), .force_in(force_in), .interrupt_acknowledge_valid(interrupt_acknowledge_valid),
    .interrupt_acknowledge_level(interrupt_acknowledge_level), .interrupt_acknowledge_vector(interrupt_acknowledge_vector), .interrupt_acknowledge_done(interrupt_acknowledge_done));
  iapr_core_model iapr_core_model_inst (.clk_sys(clk_sys), .interrupt_acknowledge_valid(interrupt_acknowledge_valid),
    .interrupt_acknowledge_level(interrupt_acknowledge_level), .interrupt_acknowledge_vector(interrupt_acknowledge_vector), .interrupt_acknowledge_done(interrupt_acknowledge_done));

  // 125 MHz
  always #4 clk_sys = ~clk_sys;

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    bit ok;
    ok = 1'b0;
    q  = 32'h0;
    @(posedge clk_sys);
    avs_read       <= !wr;
    avs_write      <= wr;
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) begin
        q  = avs_readdata;
        ok = 1'b1;
      end
    end
    avs_read    <= 1'b0;
    avs_write   <= 1'b0;
    avs_address <= ~a;
    if (!ok) begin
      n_fail++;
      end_sim();
    end
  endtask : bus

  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask : wr

  task automatic rdchk(input string what, input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk(what, exp, q);
  endtask : rdchk

  task automatic ackchk(input logic [2:0] lvl, input int gap, input logic [7:0] exp);
    logic [7:0] v;
    bit         ok;
    iapr_core_model_inst.ack(lvl, gap, v, ok);
    if (!ok) begin
      n_fail++;
      end_sim();
    end
    chk("implicit vector", {24'h0, exp}, {24'h0, v});
  endtask : ackchk

  initial begin
    clk_sys = 1'b0; rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 10'h0;
    avs_writedata = 32'h0; avs_byteenable = 4'hf; irq_raw = '0; mask_in = '0; force_in = '0;
    rows = '{'{64'h300, 0, 0, 10'h02c, 8'h48, 8'h35}, '{64'h308, 0, 0, 10'h02c, 8'h48, 8'h35},
             '{64'h208, 0, 0, 10'h02c, 8'h43, 8'h38}, '{64'h700, 0, 0, 10'h004, 8'h4a, 8'h57},
             '{64'h700, 0, 0, 10'h04c, 8'h48, 8'h35}, '{64'h420, 0, 0, 10'h034, 8'h4a, 8'h57},
             '{64'h900, 64'h800, 0, 10'h02c, 8'h48, 8'h35}, '{64'h100, 64'h1, 0, 10'h004, 8'h00, 8'h00},
             '{64'h0, 64'h1, 64'h200, 10'h004, 8'h49, 8'h32}, '{64'h400, 0, 0, 10'h02c, 8'h00, 8'h00},
             '{64'h0, 0, 0, 10'h004, 8'h00, 8'h00}};
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    // Unique level and rank pairs only
    wr(10'h120, 32'h1d, 4'hf);
    wr(10'h124, 32'h1a, 4'hf);
    wr(10'h128, 32'h2f, 4'hf);
    wr(10'h12c, 32'h1f, 4'hf);
    rdchk("ctrl 8", 10'h120, 32'h1d);
    foreach (rows[i]) begin
      @(posedge clk_sys);
      irq_raw  <= rows[i].irq;
      mask_in  <= rows[i].msk;
      force_in <= rows[i].frc;
      rdchk("ack vector", rows[i].adr, {24'h0, rows[i].vec});
      rdchk("record", 10'h000, {24'h0, rows[i].lp});
      if (rows[i].adr[9:5] == 5'h01) begin
        ackchk(rows[i].adr[4:2], i % 3, rows[i].vec);
        rdchk("implicit record", 10'h000, {24'h0, rows[i].lp});
      end
      $display("row %0d done", i);
    end
    wr(10'h10c, 32'h3f, 4'hf);
    rdchk("fixed ctrl", 10'h10c, 32'h18);
    wr(10'h130, 32'hff, 4'hf);
    rdchk("reserved bits", 10'h130, 32'h3f);
    wr(10'h130, 32'h00, 4'he);
    rdchk("byte lane off", 10'h130, 32'h3f);
    rdchk("unmapped", 10'h3fc, 32'h0);
    $display("access tests done");
    @(posedge clk_sys);
    irq_raw <= 64'h700;
    mask_in <= '0;
    fork
      rdchk("collide sw", 10'h004, 32'h4a);
      ackchk(3'h5, 1, 8'h4a);
    join
    rdchk("collide record", 10'h000, 32'h57);
    $display("collision test done");
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rdchk("ctrl after reset", 10'h120, 32'h0);
    rdchk("record after reset", 10'h000, 32'h0);
    $display("reset test done");
    end_sim();
  end
endmodule : tb
